//--- hw/aprs_top.sv
`timescale 1ns/10ps
`default_nettype none
module aprs_top (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control pins from the host
  input wire logic convert_strobe_n,
  input wire logic rd_conv,
  input wire logic upper_byte_select,
  input wire logic reset_pin,
  // sampled analog value, held by the converter core
  input wire logic [aprs_pkg::RES_W-1:0] sample_in,
  // status
  output logic eoc_n,
  output logic ref_powered,
  output logic conv_busy,
  // word-wide result bus
  output logic [aprs_pkg::RES_W-1:0] result_bus_o,
  output logic result_bus_oe,
  // byte-wide result bus
  output logic [aprs_pkg::BYTE_W-1:0] byte_bus_o,
  output logic byte_bus_oe
);
  import aprs_pkg::*;

  typedef struct packed {
    aprs_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [RES_W-1:0] sample;
    logic [RES_W-1:0] result;
    logic ref_keep;
    logic eoc_n;
    logic drive;
    logic [BYTE_W-1:0] byte_out;
  } aprs_core_t;

  aprs_core_t st_r;
  aprs_core_t st_nxt;
  aprs_pins_if pins ();

  aprs_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .convert_strobe_n(convert_strobe_n),
    .rd_conv(rd_conv),
    .upper_byte_select(upper_byte_select),
    .reset_pin(reset_pin),
    .pins(pins)
  );

  function automatic logic [BYTE_W-1:0] pick_byte(input logic [RES_W-1:0] w,
      input logic hi);
    pick_byte = hi ? w[RES_W-1:BYTE_W] : w[BYTE_W-1:0]; // [R7]
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.byte_out = pick_byte(st_r.result, pins.upper_byte_select); // [R7]
    case (st_r.state)
      APRS_OFF: begin
        // a fall with select high is not a legal first edge: stay asleep
        if (pins.strobe_fall && !pins.rd_conv) begin
          st_nxt.state = APRS_ACQ; // [R1]
        end
      end
      APRS_ACQ: begin
        if (pins.strobe_fall) begin
          st_nxt.state = APRS_CONV; // [R6]
          st_nxt.ref_keep = !pins.rd_conv; // [R2]
          st_nxt.sample = sample_in;
          st_nxt.cnt = CNT_RST;
        end
      end
      APRS_CONV: begin
        st_nxt.cnt = st_r.cnt + 1'b1;
        if (st_r.cnt == CONV_LAST) begin
          st_nxt.state = APRS_DONE;
          st_nxt.result = st_r.sample;
          st_nxt.eoc_n = 1'b0; // [R4]
        end
      end
      APRS_DONE: begin
        // a fall with select low here is ignored; the result keeps waiting
        if (pins.strobe_fall && pins.rd_conv) begin
          st_nxt.state = APRS_READ; // [R3]
          st_nxt.drive = 1'b1; // [R5]
        end
      end
      APRS_READ: begin
        if (pins.strobe_high) begin
          st_nxt.state = APRS_OFF;
          st_nxt.drive = 1'b0; // [R5]
          st_nxt.eoc_n = 1'b1;
        end
      end
      default: begin
        st_nxt.state = APRS_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst || pins.pin_rst) begin // [R8]
      st_r.state <= APRS_OFF;
      st_r.cnt <= CNT_RST;
      st_r.sample <= RES_RST;
      st_r.result <= RES_RST;
      st_r.ref_keep <= 1'b0;
      st_r.eoc_n <= 1'b1;
      st_r.drive <= 1'b0;
      st_r.byte_out <= BYTE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // reference stays on while awake, and after conversion only if kept
  assign ref_powered = (st_r.state == APRS_ACQ) || (st_r.state == APRS_CONV) ||
    st_r.ref_keep;
  assign conv_busy = (st_r.state == APRS_CONV);
  assign eoc_n = st_r.eoc_n; // [R4]
  assign result_bus_o = st_r.result; // [R5]
  assign result_bus_oe = st_r.drive; // [R5]
  assign byte_bus_o = st_r.byte_out;
  assign byte_bus_oe = st_r.drive;
endmodule // aprs_top
`default_nettype wire

//--- hw/aprs_pkg.sv
// Function
// [R1] A strobe fall with select low powers the converter up into acquisition, and the host holds select low there.
// [R2] Select sampled at the second strobe fall powers the reference down when high and keeps it on when low.
// [R3] A strobe fall with select high after conversion puts the valid result on the outputs, and the host holds select high there.
// [R4] The active-low end-of-conversion output goes low once a conversion completes.
// [R5] Result bits leave on three-state outputs enabled only during a read, with the top bit as the msb.
// [R6] The second strobe fall starts a conversion after the acquisition begun at the first.
// [R7] On the byte-wide outputs, byte select 1 gives the high result byte and 0 the low byte.
// [R8] A high level on the reset pin returns the device to its reset state.
// [R9] The host counts strobe edges and issues the reading edge only after end-of-conversion has gone low.
package aprs_pkg;
  localparam int RES_W = 16;
  localparam int BYTE_W = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 4700;
  localparam int CONV_CYC = (CONV_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
  localparam logic [RES_W-1:0] RES_RST = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [2:0] SYNC_RST_HI = 3'h7;
  localparam logic [2:0] SYNC_RST_LO = 3'h0;

  typedef enum logic [4:0] {
    APRS_OFF = 5'h01,
    APRS_ACQ = 5'h02,
    APRS_CONV = 5'h04,
    APRS_DONE = 5'h08,
    APRS_READ = 5'h10
  } aprs_state_t;
endpackage

//--- hw/aprs_pins_if.sv
`timescale 1ns/10ps
`default_nettype none
interface aprs_pins_if;
  logic strobe_fall;
  logic strobe_high;
  logic rd_conv;
  logic upper_byte_select;
  logic pin_rst;
  modport sync (output strobe_fall, output strobe_high, output rd_conv,
    output upper_byte_select, output pin_rst);
  modport core (input strobe_fall, input strobe_high, input rd_conv,
    input upper_byte_select, input pin_rst);
endinterface
`default_nettype wire

//--- hw/aprs_sync.sv
`timescale 1ns/10ps
`default_nettype none
module aprs_sync
  import aprs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // raw pins
  input wire logic convert_strobe_n,
  input wire logic rd_conv,
  input wire logic upper_byte_select,
  input wire logic reset_pin,
  // filtered side
  aprs_pins_if.sync pins
);
  typedef struct packed {
    logic [3:0][2:0] sh;
    logic [3:0] lvl;
  } aprs_sync_t;

  aprs_sync_t st_r;
  aprs_sync_t st_nxt;
  logic [3:0] raw;

  assign raw = {reset_pin, upper_byte_select, rd_conv, convert_strobe_n};

  // a level only moves once stages two and three agree, so a one-sample glitch never counts
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < 4; i++) begin
      st_nxt.sh[i] = {st_r.sh[i][1:0], raw[i]};
      if (st_r.sh[i][1] == st_r.sh[i][2]) begin
        st_nxt.lvl[i] = st_r.sh[i][2];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r.sh <= {SYNC_RST_LO, SYNC_RST_LO, SYNC_RST_LO, SYNC_RST_HI};
      st_r.lvl <= 4'h1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pins.strobe_fall = st_r.lvl[0] & ~st_nxt.lvl[0];
  assign pins.strobe_high = st_r.lvl[0];
  assign pins.rd_conv = st_r.lvl[1];
  assign pins.upper_byte_select = st_r.lvl[2];
  assign pins.pin_rst = st_r.lvl[3];
endmodule // aprs_sync
`default_nettype wire

//--- test/aprs_props.sv
`timescale 1ns/10ps
`default_nettype none
module aprs_props (
  // pins
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reset_pin,
  input wire logic upper_byte_select,
  input wire logic eoc_n,
  input wire logic ref_powered,
  input wire logic conv_busy,
  input wire logic [15:0] result_bus_o,
  input wire logic result_bus_oe,
  input wire logic [7:0] byte_bus_o,
  input wire logic byte_bus_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  oe_pair_a: assert property (byte_bus_oe == result_bus_oe) else $error("oe split");
  rst_idle_a: assert property (
    $past(sys_rst) |-> eoc_n && !result_bus_oe && !conv_busy && !ref_powered)
    else $error("not idle after reset");
  // pin reset aborts a conversion, so it cancels the wait
  conv_time_a: assert property (disable iff (sys_rst || reset_pin)
    $rose(conv_busy) |-> ##[465:475] !eoc_n) else $error("eoc late");
  busy_ref_a: assert property (conv_busy |-> ref_powered && eoc_n) else $error("ref off");
  oe_eoc_a: assert property (result_bus_oe |-> !eoc_n) else $error("read before eoc");
  byte_sel_a: assert property (
    (result_bus_oe && $stable(upper_byte_select))[*6] |->
    byte_bus_o == (upper_byte_select ? result_bus_o[15:8] : result_bus_o[7:0]))
    else $error("wrong byte");
  data_hold_a: assert property (
    result_bus_oe && $past(result_bus_oe) |-> $stable(result_bus_o))
    else $error("data moved");
  read_end_a: assert property ($fell(result_bus_oe) |-> eoc_n) else $error("eoc stuck");
  cover property (!eoc_n);
  cover property (result_bus_oe && upper_byte_select);
  cover property ($fell(ref_powered));
endmodule // aprs_props
`default_nettype wire

//--- test/aprs_host.sv
`timescale 1ns/10ps
`default_nettype none
module aprs_host (
  // device pins
  input wire logic clk,
  input wire logic eoc_n,
  output logic convert_strobe_n,
  output logic rd_conv,
  output logic upper_byte_select
);
  initial begin
    convert_strobe_n = 1'h1;
    rd_conv = 1'h0;
    upper_byte_select = 1'h1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // select set 5 clk before the strobe fall and held 6 clk past the rise so the pin filter sees it
  task automatic fall(input logic rc);
    rd_conv = rc;
    tick(5);
    convert_strobe_n = 1'h0;
    tick(6);
    convert_strobe_n = 1'h1;
    tick(6);
  endtask
  task automatic read_start();
    for (int i = 0; i < 600 && eoc_n; i++) tick(1);
    rd_conv = 1'h1;
    tick(5);
    convert_strobe_n = 1'h0;
    tick(8);
  endtask
  task automatic sel(input logic hb, input logic up);
    upper_byte_select = hb;
    convert_strobe_n = up;
    tick(8);
  endtask
endmodule // aprs_host
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'h0, sys_rst = 1'h1, reset_pin = 1'h0, oe_q = 1'h0;
  logic [15:0] sample_in = 16'h0000;
  logic convert_strobe_n, rd_conv, upper_byte_select, eoc_n, ref_powered, conv_busy;
  logic result_bus_oe, byte_bus_oe;
  logic [15:0] result_bus_o;
  logic [7:0] byte_bus_o;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h0000_0d1a;
  int n_fail = 0, tests_run = 0;
  always #5 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xs = v ^ (v << 5);
  endfunction
  aprs_top aprs_top_i (.*);
  aprs_host aprs_host_i (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("fails %0d checks %0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    oe_q <= result_bus_oe;
    if (result_bus_oe && !oe_q) chk(result_bus_o, exp_q.pop_front());
  end
  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'h0;
    chk({eoc_n, ref_powered, conv_busy, result_bus_oe}, 16'h0008);
    aprs_host_i.fall(1'h1);
    chk({eoc_n, conv_busy, ref_powered}, 16'h0004);
    for (int k = 0; k < 6; k++) begin
      seed = xs(seed);
      sample_in = seed[15:0];
      aprs_host_i.fall(1'h0);
      chk(ref_powered, 16'h0001);
      aprs_host_i.fall(seed[16]);
      sample_in = ~seed[15:0]; // capture must already be done
      chk({conv_busy, eoc_n}, 16'h0003);
      if (k == 5) begin
        reset_pin = 1'h1;
        aprs_host_i.tick(6);
        reset_pin = 1'h0;
        aprs_host_i.tick(6);
        chk({eoc_n, conv_busy, ref_powered}, 16'h0004);
      end else begin
        exp_q.push_back(seed[15:0]);
        aprs_host_i.read_start();
        chk(byte_bus_o, seed[15:8]);
        aprs_host_i.sel(1'h0, 1'h0);
        chk(byte_bus_o, seed[7:0]);
        aprs_host_i.sel(1'h1, 1'h1);
        chk({eoc_n, result_bus_oe, ref_powered}, {13'h0000, 2'h2, ~seed[16]});
      end
    end
    report_and_stop();
  end
endmodule // tb_top
bind aprs_top aprs_props aprs_props_i (.*);
`default_nettype wire
